// ---- hdl/mcs_pkg.sv ----
// Purpose: shared constants for the MII collision / carrier sense block
// Assumes: ref_clk at 100 MHz
// Notes: management register 18 holds the SQE test inhibit at bit 2
package mcs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int RXCLK_10_HZ = 2_500_000;
  localparam int RXCLK_100_HZ = 25_000_000;
  localparam logic [5:0] RXC_HALF_10_M1 = 6'(REF_CLK_HZ / (2 * RXCLK_10_HZ) - 1);
  localparam logic [5:0] RXC_HALF_100_M1 = 6'(REF_CLK_HZ / (2 * RXCLK_100_HZ) - 1);
  // sqe test pulse: gap after transmit end, then pulse width
  localparam int SQE_DELAY_NS = 1000;
  localparam int SQE_LEN_NS = 1000;
  localparam logic [7:0] SQE_DELAY_CYC = 8'((SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SQE_LEN_CYC = 8'((SQE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SYM_BITS = 10;
  localparam logic [3:0] SYM_LAST = 4'h9;
  // management frame
  localparam logic [5:0] MD_PRE_ONES = 6'h20;
  localparam logic [4:0] MD_HDR_LAST = 5'h0C;
  localparam logic [4:0] MD_RD_LAST = 5'h10;
  localparam logic [4:0] MD_WR_LAST = 5'h11;
  localparam logic [1:0] MD_OP_RD = 2'h2;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [4:0] REG_SQE = 5'h12;
  localparam int SQE_INH_BIT = 2;
  localparam logic [15:0] MGMT_RESET = 16'h0000;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PULSE} mcs_sqe_e;
  typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} mcs_md_e;
endpackage : mcs_pkg

// ---- hdl/mcs_mdio.sv ----
// Purpose: serial management engine clocked by the management clock
// Assumes: status and phy_addr are quasi-static relative to mdc
// Notes: write results leave through a toggle with address and data held
`timescale 1ns/1ps
`default_nettype none
module mcs_mdio
  import mcs_pkg::*;
(
  input wire logic mdc,
  input wire logic rst_n,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] status,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  output logic wr_tgl,
  output logic [4:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [20:0] sync1_reg;
  logic [20:0] sync2_reg;
  mcs_md_e state_reg, state_next;
  logic [5:0] ones_reg, ones_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [12:0] hdr_reg, hdr_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0] radr_reg, radr_next;
  logic is_wr_reg, is_wr_next;
  logic o_reg, o_next;
  logic oe_n_reg, oe_n_next;
  logic tgl_reg, tgl_next;
  logic [4:0] wa_reg, wa_next;
  logic [15:0] wd_reg, wd_next;
  logic [15:0] rd_data;
  logic [20:0] sync_in;

  assign sync_in = {phy_addr, status};

  // per-bit two-stage synchroniser for straps and status
  for (genvar i = 0; i < 21; i++) begin : g_sync
    always_ff @(posedge mdc or negedge rst_n) begin
      if (!rst_n) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= sync_in[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  assign rd_data = (radr_reg == REG_SQE) ? sync2_reg[15:0] : 16'h0000;

  // every transfer is timed by mdc edges only
  always_comb begin
    state_next = state_reg;
    ones_next = ones_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    sh_next = sh_reg;
    radr_next = radr_reg;
    is_wr_next = is_wr_reg;
    o_next = o_reg;
    oe_n_next = oe_n_reg;
    tgl_next = tgl_reg;
    wa_next = wa_reg;
    wd_next = wd_reg;
    unique case (state_reg)
      MD_PRE: begin
        if (mdio_i) begin
          ones_next = (ones_reg == MD_PRE_ONES) ? ones_reg : ones_reg + 6'h01;
        end else begin
          if (ones_reg == MD_PRE_ONES) begin
            state_next = MD_HDR;
            cnt_next = 5'h00;
          end
          ones_next = 6'h00;
        end
      end
      MD_HDR: begin
        hdr_next = {hdr_reg[11:0], mdio_i};
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == MD_HDR_LAST) begin
          state_next = MD_PRE;
          cnt_next = 5'h00;
          radr_next = hdr_next[4:0];
          if (hdr_next[12] && hdr_next[9:5] == sync2_reg[20:16]) begin
            if (hdr_next[11:10] == MD_OP_RD) begin
              state_next = MD_TA;
            end else if (hdr_next[11:10] == MD_OP_WR) begin
              state_next = MD_DATA;
              is_wr_next = 1'b1;
            end
          end
        end
      end
      MD_TA: begin
        // second turnaround bit driven low by the device
        o_next = 1'b0;
        oe_n_next = 1'b0;
        sh_next = rd_data;
        is_wr_next = 1'b0;
        cnt_next = 5'h00;
        state_next = MD_DATA;
      end
      MD_DATA: begin
        cnt_next = cnt_reg + 5'h01;
        if (is_wr_reg) begin
          sh_next = {sh_reg[14:0], mdio_i};
          if (cnt_reg == MD_WR_LAST) begin
            wa_next = radr_reg;
            wd_next = sh_next;
            tgl_next = ~tgl_reg;
            is_wr_next = 1'b0;
            state_next = MD_PRE;
          end
        end else if (cnt_reg == MD_RD_LAST) begin
          o_next = 1'b1;
          oe_n_next = 1'b1;
          state_next = MD_PRE;
        end else begin
          o_next = sh_reg[15];
          sh_next = {sh_reg[14:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= MD_PRE;
      ones_reg <= 6'h00;
      cnt_reg <= 5'h00;
      hdr_reg <= 13'h0000;
      sh_reg <= 16'h0000;
      radr_reg <= 5'h00;
      is_wr_reg <= 1'b0;
      o_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      tgl_reg <= 1'b0;
      wa_reg <= 5'h00;
      wd_reg <= MGMT_RESET;
    end else begin
      state_reg <= state_next;
      ones_reg <= ones_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      sh_reg <= sh_next;
      radr_reg <= radr_next;
      is_wr_reg <= is_wr_next;
      o_reg <= o_next;
      oe_n_reg <= oe_n_next;
      tgl_reg <= tgl_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
    end
  end

  assign mdio_o = o_reg;
  assign mdio_oe_n = oe_n_reg;
  assign wr_tgl = tgl_reg;
  assign wr_addr = wa_reg;
  assign wr_data = wd_reg;

  rd_drive_a: assert property (@(posedge mdc) disable iff (!rst_n)
    state_reg == MD_TA |=> !mdio_oe_n ##1 !mdio_oe_n [*8])
    else $error("device did not drive turnaround and read data");
endmodule : mcs_mdio
`default_nettype wire

// ---- hdl/mcs_top.sv ----
// How it works
// - In half duplex, receive activity seen while TXEN is high raises the collision output.
// - In 10 Mb/s mode receive activity is taken from the unsquelched line activity input.
// - In 100 Mb/s mode a 10-bit symbol with two non-adjacent zeros flags receive activity.
// - Collision is driven from ref_clk, unrelated to the MII clocks, so the MAC must sync it.
// - Full duplex disables collision signalling and keeps the collision output low.
// - An SQE test pulse follows each half-duplex 10 Mb/s transmission unless sqe_test_inhibit or the inhibit bit 18.2 is set.
// - In half duplex without repeater mode carrier sense follows receive or transmit activity.
// - In full duplex or repeater mode carrier sense follows receive activity only.
// - Carrier sense is not aligned to either MII clock, so the MAC must sync it.
// - All management transfers on the data line are timed by the management clock.
// - The block drives rx_clk and launches rxd, rx_dv and rx_er on its falling edge.
// - rx_clk runs at 2.5 MHz in 10 Mb/s mode and 25 MHz in 100 Mb/s mode.
//
// Purpose: collision, carrier sense, receive clock and management for a PHY MII
// Assumes: mode inputs and receive nibble inputs come from logic on ref_clk
// Notes: tx_en and line_rx_activity are pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module mcs_top
  import mcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic repeater_mode,
  input wire logic sqe_test_inhibit,
  input wire logic tx_en,
  input wire logic line_rx_activity,
  input wire logic sym_bit,
  input wire logic sym_bit_valid,
  input wire logic [3:0] rxd_in,
  input wire logic rx_dv_in,
  input wire logic rx_er_in,
  input wire logic [4:0] phy_addr,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  output logic col,
  output logic crs,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er
);
  // pin synchronisers
  logic tx_s1_reg, tx_s2_reg, tx_d_reg;
  logic line_s1_reg, line_s2_reg;
  logic tgl_s1_reg, tgl_s2_reg, tgl_d_reg;
  // activity detection
  logic [SYM_BITS-1:0] sym_reg, sym_next;
  logic [3:0] symcnt_reg, symcnt_next;
  logic act100_reg, act100_next;
  logic [SYM_BITS-1:0] sym_full;
  logic sym_done;
  logic rx_act;
  // sqe test
  mcs_sqe_e sq_reg, sq_next;
  logic [7:0] sqcnt_reg, sqcnt_next;
  logic sqe_inh;
  // outputs
  logic col_reg, col_next;
  logic crs_reg, crs_next;
  // receive clock
  logic [5:0] div_reg, div_next;
  logic rxc_reg, rxc_next;
  logic [3:0] rxd_reg, rxd_next;
  logic dv_reg, dv_next;
  logic er_reg, er_next;
  logic [5:0] half_m1;
  logic rxc_fall;
  // management
  logic inh_reg, inh_next;
  logic md_tgl;
  logic [4:0] md_addr;
  logic [15:0] md_data;
  logic [15:0] status;
  logic md_wr;

  function automatic logic nonadj_zeros(input logic [SYM_BITS-1:0] s);
    logic r;
    r = 1'b0;
    for (int i = 0; i < SYM_BITS - 2; i++) begin
      for (int j = i + 2; j < SYM_BITS; j++) begin
        r = r | (~s[i] & ~s[j]);
      end
    end
    return r;
  endfunction : nonadj_zeros

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_s1_reg <= 1'b0;
      tx_s2_reg <= 1'b0;
      tx_d_reg <= 1'b0;
      line_s1_reg <= 1'b0;
      line_s2_reg <= 1'b0;
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_d_reg <= 1'b0;
    end else begin
      tx_s1_reg <= tx_en;
      tx_s2_reg <= tx_s1_reg;
      tx_d_reg <= tx_s2_reg;
      line_s1_reg <= line_rx_activity;
      line_s2_reg <= line_s1_reg;
      tgl_s1_reg <= md_tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_d_reg <= tgl_s2_reg;
    end
  end

  // symbol assembly and activity
  assign sym_full = {sym_reg[SYM_BITS-2:0], sym_bit};
  assign sym_done = sym_bit_valid && symcnt_reg == SYM_LAST;
  assign rx_act = speed_100 ? act100_reg : line_s2_reg;

  always_comb begin
    sym_next = sym_reg;
    symcnt_next = symcnt_reg;
    act100_next = act100_reg;
    if (sym_bit_valid) begin
      sym_next = sym_full;
      symcnt_next = sym_done ? 4'h0 : symcnt_reg + 4'h1;
    end
    if (sym_done) begin
      act100_next = nonadj_zeros(sym_full);
    end
    if (!speed_100) begin
      act100_next = 1'b0;
      symcnt_next = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_reg <= '1;
      symcnt_reg <= 4'h0;
      act100_reg <= 1'b0;
    end else begin
      sym_reg <= sym_next;
      symcnt_reg <= symcnt_next;
      act100_reg <= act100_next;
    end
  end

  // sqe test after each half-duplex 10 Mb/s transmission
  assign sqe_inh = sqe_test_inhibit | inh_reg;

  always_comb begin
    sq_next = sq_reg;
    sqcnt_next = sqcnt_reg;
    unique case (sq_reg)
      SQ_IDLE: begin
        if (tx_d_reg && !tx_s2_reg && !speed_100 && !full_duplex) begin
          sq_next = SQ_WAIT;
          sqcnt_next = SQE_DELAY_CYC - 8'h01;
        end
      end
      SQ_WAIT: begin
        sqcnt_next = sqcnt_reg - 8'h01;
        if (sqcnt_reg == 8'h00) begin
          sq_next = SQ_PULSE;
          sqcnt_next = SQE_LEN_CYC - 8'h01;
        end
      end
      SQ_PULSE: begin
        sqcnt_next = sqcnt_reg - 8'h01;
        if (sqcnt_reg == 8'h00) begin
          sq_next = SQ_IDLE;
        end
      end
      default: begin
        sq_next = SQ_IDLE;
      end
    endcase
    if (sqe_inh || tx_s2_reg) begin
      sq_next = SQ_IDLE;
    end
  end

  // collision and carrier sense, launched from ref_clk only
  always_comb begin
    col_next = (rx_act && tx_s2_reg) || sq_reg == SQ_PULSE;
    if (full_duplex) begin
      col_next = 1'b0;
    end
    if (full_duplex || repeater_mode) begin
      crs_next = rx_act;
    end else begin
      crs_next = rx_act || tx_s2_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_reg <= SQ_IDLE;
      sqcnt_reg <= 8'h00;
      col_reg <= 1'b0;
      crs_reg <= 1'b0;
    end else begin
      sq_reg <= sq_next;
      sqcnt_reg <= sqcnt_next;
      col_reg <= col_next;
      crs_reg <= crs_next;
    end
  end

  // receive clock divider and nibble launch
  assign half_m1 = speed_100 ? RXC_HALF_100_M1 : RXC_HALF_10_M1;
  assign rxc_fall = rxc_reg && div_reg >= half_m1;

  always_comb begin
    div_next = div_reg + 6'h01;
    rxc_next = rxc_reg;
    rxd_next = rxd_reg;
    dv_next = dv_reg;
    er_next = er_reg;
    if (div_reg >= half_m1) begin
      div_next = 6'h00;
      rxc_next = ~rxc_reg;
    end
    if (rxc_fall) begin
      rxd_next = rxd_in;
      dv_next = rx_dv_in;
      er_next = rx_er_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 6'h00;
      rxc_reg <= 1'b0;
      rxd_reg <= 4'h0;
      dv_reg <= 1'b0;
      er_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      rxc_reg <= rxc_next;
      rxd_reg <= rxd_next;
      dv_reg <= dv_next;
      er_reg <= er_next;
    end
  end

  // management writes arrive as a toggle, address and data already stable
  assign md_wr = tgl_s2_reg ^ tgl_d_reg;

  always_comb begin
    inh_next = inh_reg;
    if (md_wr && md_addr == REG_SQE) begin
      inh_next = md_data[SQE_INH_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inh_reg <= MGMT_RESET[SQE_INH_BIT];
    end else begin
      inh_reg <= inh_next;
    end
  end

  assign status = {11'h000, full_duplex, speed_100, inh_reg, crs_reg, col_reg};

  mcs_mdio u_mdio (
    .mdc(mdc),
    .rst_n(rst_n),
    .phy_addr(phy_addr),
    .status(status),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n),
    .wr_tgl(md_tgl),
    .wr_addr(md_addr),
    .wr_data(md_data)
  );

  assign col = col_reg;
  assign crs = crs_reg;
  assign rx_clk = rxc_reg;
  assign rxd = rxd_reg;
  assign rx_dv = dv_reg;
  assign rx_er = er_reg;

  col_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !full_duplex && rx_act && tx_s2_reg |=> col)
    else $error("collision missed during transmit");
  col_fdx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    full_duplex && $past(full_duplex) |-> !col)
    else $error("collision raised in full duplex");
  rx10_src_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !speed_100 && !full_duplex && !tx_s2_reg ##1 !full_duplex |-> crs == $past(line_s2_reg))
    else $error("10M activity not taken from line input");
  sym_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speed_100 && sym_done |=> act100_reg == nonadj_zeros($past(sym_full)))
    else $error("symbol activity flag wrong");
  sqe_inh_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sqe_inh ##1 sqe_inh |=> sq_reg == SQ_IDLE && (!col || ($past(rx_act) && $past(tx_s2_reg))))
    else $error("sqe pulse while inhibited");
  sqe_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sq_reg == SQ_PULSE) |-> $past(sq_reg) == SQ_WAIT ##1 col)
    else $error("sqe pulse not on collision output");
  crs_half_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !full_duplex && !repeater_mode && tx_s2_reg |=> crs)
    else $error("carrier sense missed own transmit");
  crs_rx_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (full_duplex || repeater_mode) && !rx_act |=> !crs)
    else $error("carrier sense raised by transmit");
  rxd_launch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$fell(rx_clk) |-> $stable(rxd) && $stable(rx_dv) && $stable(rx_er))
    else $error("receive nibble changed away from falling rx_clk");
  rxc_100_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rx_clk) && speed_100 && $stable(speed_100) ##1 speed_100 [*2] |-> $fell(rx_clk))
    else $error("rx_clk not 25 MHz");
  rxc_10_a: assert property (@(posedge ref_clk) disable iff (!rst_n || speed_100)
    $rose(rx_clk) && !speed_100 && $stable(speed_100) |-> ##19 rx_clk ##1 !rx_clk)
    else $error("rx_clk not 2.5 MHz");
  col_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(col) && tx_s2_reg);
  sqe_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) sq_reg == SQ_PULSE);
  act100_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(act100_reg));
  md_wr_c: cover property (@(posedge ref_clk) disable iff (!rst_n) md_wr);
endmodule : mcs_top
`default_nettype wire

// ---- verif/mcs_sta.sv ----
// Purpose: station management model, sources mdc and runs management frames
// Assumes: mdc period 32 ns, held low between frames
// Notes: the data line has a pull-up, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module mcs_sta
  import mcs_pkg::*;
(
  input wire logic mdio_o,
  input wire logic mdio_oe_n,
  output logic mdc,
  output wire logic mdio_line
);
  logic sta_oe = 1'b0;
  logic sta_bit = 1'b1;
  initial mdc = 1'b0;
  // resolved line level from both drivers and the pull-up
  assign mdio_line = sta_oe ? sta_bit : (mdio_oe_n ? 1'b1 : mdio_o);

  // one mdc period; seen is the line just before the rising edge
  task automatic bit_cycle(input logic drive, input logic b, output logic seen);
    sta_oe = drive;
    sta_bit = b;
    #16;
    seen = mdio_line;
    mdc = 1'b1;
    #16;
    mdc = 1'b0;
  endtask : bit_cycle

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic s;
    hdr = {32'hFFFFFFFF, 2'b01, op, pa, ra};
    rd = 16'h0000;
    ta = 1'b1;
    for (int i = 45; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    for (int i = 1; i <= 18; i++) begin
      if (op == MD_OP_WR) begin
        bit_cycle(1'b1, (i == 1) ? 1'b1 : (i == 2) ? 1'b0 : wd[18 - i], s);
      end else begin
        bit_cycle(1'b0, 1'b1, s);
        if (i == 2) ta = s;
        if (i >= 3) rd[18 - i] = s;
      end
    end
    bit_cycle(1'b0, 1'b1, s);
    sta_oe = 1'b0;
  endtask : frame
endmodule : mcs_sta
`default_nettype wire

// ---- verif/mcs_top_test.sv ----
// Purpose: self-checking bench for collision, carrier sense, rx clock and management
// Assumes: ref_clk 100 MHz, mdc from the station model
// Notes: col and crs are sampled a few cycles after each change, as a synchronising MAC would
`timescale 1ns/1ps
`default_nettype none
module mcs_top_test;
  import mcs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic speed_100 = 1'b0, full_duplex = 1'b0, repeater_mode = 1'b0, sqe_test_inhibit = 1'b0;
  logic tx_en = 1'b0, line_rx_activity = 1'b0, sym_bit = 1'b1, sym_bit_valid = 1'b0;
  logic [3:0] rxd_in = 4'h0;
  logic rx_dv_in = 1'b0, rx_er_in = 1'b0;
  logic [4:0] phy_addr = 5'h0B;
  logic mdc, mdio_i, mdio_o, mdio_oe_n, col, crs, rx_clk, rx_dv, rx_er, prev, ta;
  logic [3:0] rxd;
  logic [5:0] cap;
  logic [15:0] rd;
  int num_errors = 0;
  int checks = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rxd_in <= 4'($urandom);
    rx_dv_in <= 1'($urandom);
    rx_er_in <= 1'($urandom);
  end

  mcs_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .mdc(mdc), .speed_100(speed_100),
    .full_duplex(full_duplex), .repeater_mode(repeater_mode),
    .sqe_test_inhibit(sqe_test_inhibit), .tx_en(tx_en), .line_rx_activity(line_rx_activity),
    .sym_bit(sym_bit), .sym_bit_valid(sym_bit_valid), .rxd_in(rxd_in), .rx_dv_in(rx_dv_in),
    .rx_er_in(rx_er_in), .phy_addr(phy_addr), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n), .col(col), .crs(crs), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
    .rx_er(rx_er));
  mcs_sta sta (.mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_line(mdio_i));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  function automatic int act100(input logic [9:0] s);
    for (int i = 0; i < 10; i++)
      for (int j = i + 2; j < 10; j++)
        if (!s[i] && !s[j]) return 1;
    return 0;
  endfunction : act100

  // expected col/crs from the mode and activity
  task automatic expect_link(input int fd, input int rep, input int tx, input int act);
    check({15'h0000, col}, 16'((fd == 0 && tx != 0 && act != 0) ? 1 : 0), "col");
    check({15'h0000, crs}, 16'((fd != 0 || rep != 0) ? act : (act | tx)), "crs");
  endtask : expect_link

  task automatic send_sym(input logic [9:0] s);
    for (int i = 9; i >= 0; i--) begin
      @(posedge ref_clk);
      sym_bit <= s[i];
      sym_bit_valid <= 1'b1;
      @(posedge ref_clk);
      sym_bit_valid <= 1'b0;
    end
  endtask : send_sym

  task automatic sqe_run(input int exp_cnt);
    int n;
    int first;
    n = 0;
    first = 999;
    @(posedge ref_clk);
    tx_en <= 1'b1;
    repeat (10) @(posedge ref_clk);
    tx_en <= 1'b0;
    for (int c = 0; c < 300; c++) begin
      @(posedge ref_clk);
      #1;
      if (col === 1'b1) begin
        n++;
        if (first == 999) first = c;
      end
    end
    check(16'(n), 16'(exp_cnt), "sqe pulse length");
    if (exp_cnt > 0) check({15'h0000, first >= int'(SQE_DELAY_CYC)}, 16'h0001, "sqe gap");
    $display("sqe test done, expected %0d", exp_cnt);
  endtask : sqe_run

  task automatic tick;
    prev = rx_clk;
    @(posedge ref_clk);
    cap = {rxd_in, rx_dv_in, rx_er_in};
    #1;
  endtask : tick

  task automatic rx_run(input logic sp);
    int n;
    @(posedge ref_clk);
    speed_100 <= sp;
    repeat (60) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin tick(); n++; end while (!(rx_clk === 1'b1 && prev === 1'b0) && n < 100);
      n = 0;
      do begin tick(); n++; end while (!(rx_clk === 1'b0 && prev === 1'b1) && n < 100);
      if (n >= 100) begin
        num_errors++;
        results();
      end
      check(16'(n), sp ? 16'h0002 : 16'h0014, "rx_clk half period");
      check({10'h000, rxd, rx_dv, rx_er}, {10'h000, cap}, "rx nibble");
    end
    $display("rx clock test done, speed %0d", sp);
  endtask : rx_run

  initial begin
    logic [9:0] s;
    // a real falling edge, so the mdc-side flops reset while mdc stands still
    rst_n <= 1'b0;
    void'($urandom(32417));
    repeat (3) @(posedge ref_clk);
    #1;
    check({5'h00, col, crs, rx_clk, rxd, rx_dv, rx_er, mdio_o, mdio_oe_n},
          16'h0003, "reset");
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    sqe_test_inhibit <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      @(posedge ref_clk);
      full_duplex <= m[0];
      repeater_mode <= m[1];
      tx_en <= m[2];
      line_rx_activity <= m[3];
      repeat (5) @(posedge ref_clk);
      #1;
      expect_link(m & 1, (m >> 1) & 1, (m >> 2) & 1, (m >> 3) & 1);
    end
    $display("10M mode table done");
    @(posedge ref_clk);
    speed_100 <= 1'b1;
    line_rx_activity <= 1'b1;
    for (int n = 0; n < 10; n++) begin
      s = (n == 0) ? 10'h3F9 : (n == 1) ? 10'h3FA : (n == 2) ? 10'h3FF : 10'($urandom);
      full_duplex <= 1'($urandom);
      repeater_mode <= 1'($urandom);
      tx_en <= 1'($urandom);
      send_sym(s);
      repeat (4) @(posedge ref_clk);
      #1;
      expect_link(full_duplex, repeater_mode, tx_en, act100(s));
    end
    $display("100M symbol test done");
    @(posedge ref_clk);
    speed_100 <= 1'b0;
    {full_duplex, repeater_mode, tx_en, line_rx_activity, sqe_test_inhibit} <= 5'h00;
    repeat (10) @(posedge ref_clk);
    sqe_run(int'(SQE_LEN_CYC));
    sqe_test_inhibit <= 1'b1;
    sqe_run(0);
    sqe_test_inhibit <= 1'b0;
    full_duplex <= 1'b1;
    repeat (10) @(posedge ref_clk);
    sta.frame(MD_OP_RD, phy_addr, REG_SQE, 16'h0000, rd, ta);
    check({15'h0000, ta}, 16'h0000, "read turnaround");
    check(rd, 16'h0010, "status read");
    full_duplex <= 1'b0;
    sta.frame(MD_OP_WR, phy_addr, REG_SQE, 16'h0004, rd, ta);
    repeat (10) @(posedge ref_clk);
    sta.frame(MD_OP_RD, phy_addr, REG_SQE, 16'h0000, rd, ta);
    check(rd, 16'h0004, "inhibit readback");
    sta.frame(MD_OP_RD, phy_addr ^ 5'h01, REG_SQE, 16'h0000, rd, ta);
    check({rd[14:0], ta}, 16'hFFFF, "foreign address");
    $display("management test done");
    sqe_run(0);
    rx_run(1'b0);
    rx_run(1'b1);
    results();
  end
endmodule : mcs_top_test
`default_nettype wire
